// file: design/xcvr_top.sv
// module: apb-controlled 16-bit registered bus transceiver
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module xcvr_top
  import xcvr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [BUS_W-1:0] a_in,
  output logic [BUS_W-1:0] a_out,
  output logic [BUS_W-1:0] a_oe,
  input wire logic [BUS_W-1:0] b_in,
  output logic [BUS_W-1:0] b_out,
  output logic [BUS_W-1:0] b_oe,
  input wire logic [LANES-1:0] a_to_b_capture_clock,
  input wire logic [LANES-1:0] b_to_a_capture_clock
);
  // ----------------------------------------------------------------
  // pin synchronisers: two flops before any logic
  // ----------------------------------------------------------------
  logic [BUS_W-1:0] a_s1_ff, a_s2_ff, b_s1_ff, b_s2_ff;
  logic [LANES-1:0] cab_s1_ff, cab_s2_ff, cab_s3_ff;
  logic [LANES-1:0] cba_s1_ff, cba_s2_ff, cba_s3_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_s1_ff <= 16'h0000;
      a_s2_ff <= 16'h0000;
      b_s1_ff <= 16'h0000;
      b_s2_ff <= 16'h0000;
      cab_s1_ff <= 2'h0;
      cab_s2_ff <= 2'h0;
      cab_s3_ff <= 2'h0;
      cba_s1_ff <= 2'h0;
      cba_s2_ff <= 2'h0;
      cba_s3_ff <= 2'h0;
    end else begin
      a_s1_ff <= a_in;
      a_s2_ff <= a_s1_ff;
      b_s1_ff <= b_in;
      b_s2_ff <= b_s1_ff;
      cab_s1_ff <= a_to_b_capture_clock;
      cab_s2_ff <= cab_s1_ff;
      cab_s3_ff <= cab_s2_ff;
      cba_s1_ff <= b_to_a_capture_clock;
      cba_s2_ff <= cba_s1_ff;
      cba_s3_ff <= cba_s2_ff;
    end
  end
  // rising edges of the capture clocks, taken after synchronising
  wire logic [LANES-1:0] cab_rise = cab_s2_ff & ~cab_s3_ff;
  wire logic [LANES-1:0] cba_rise = cba_s2_ff & ~cba_s3_ff;
  // ----------------------------------------------------------------
  // apb slave: zero wait states
  // ----------------------------------------------------------------
  logic mode_wide_ff;
  logic [CTL_W-1:0] ctl_lo_ff, ctl_hi_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  wire logic access = psel && penable;
  wire logic hit_mode = paddr == OFS_MODE;
  wire logic hit_lo = paddr == OFS_CTL_LO;
  wire logic hit_hi = paddr == OFS_CTL_HI;
  wire logic hit_store = paddr == OFS_STORE;
  wire logic hit_stat = paddr == OFS_STATUS;
  wire logic hit_any = hit_mode | hit_lo | hit_hi | hit_store | hit_stat;
  wire logic [LANE_W-1:0] ab_st [LANES];
  wire logic [LANE_W-1:0] ba_st [LANES];
  logic [LANES-1:0] a_oe_l, b_oe_l;
  // store register: both captured words, each 16 bits
  wire logic [31:0] store_word = {ba_st[1], ba_st[0], ab_st[1], ab_st[0]};
  // status shows which bus each lane drives now
  wire logic [31:0] stat_word = {28'h0000000, b_oe_l, a_oe_l};
  wire logic [31:0] nxt_prdata =
    hit_mode ? {31'h00000000, mode_wide_ff} :
    hit_lo ? {27'h0000000, ctl_lo_ff} :
    hit_hi ? {27'h0000000, ctl_hi_ff} :
    hit_store ? store_word :
    hit_stat ? stat_word : 32'h00000000;
  // unmapped accesses and read-only writes answer with an error, nothing stored
  wire logic wr_ok = access && pwrite && (hit_mode | hit_lo | hit_hi);
  wire logic nxt_err = !hit_any || (pwrite && (hit_store || hit_stat));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_wide_ff <= MODE_RST;
      ctl_lo_ff <= CTL_RST;
      ctl_hi_ff <= CTL_RST;
    end else if (wr_ok) begin
      if (hit_mode) mode_wide_ff <= pwdata[MODE_WIDE];
      if (hit_lo) ctl_lo_ff <= pwdata[CTL_W-1:0];
      if (hit_hi) ctl_hi_ff <= pwdata[CTL_W-1:0];
    end
  end
  // read data and error are registered during setup, shown in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff <= (psel && !penable && !pwrite) ? nxt_prdata : 32'h0;
      pslverr_ff <= psel && !penable && nxt_err;
    end
  end
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;
  assign pready = 1'b1; // constant, ready every access phase
  // ----------------------------------------------------------------
  // lanes: wide mode ties the upper lane to the lower controls
  // ----------------------------------------------------------------
  wire logic [CTL_W-1:0] ctl_up = mode_wide_ff ? ctl_lo_ff : ctl_hi_ff;
  wire logic [LANES-1:0] cab_l = mode_wide_ff ? {2{cab_rise[0]}} : cab_rise;
  wire logic [LANES-1:0] cba_l = mode_wide_ff ? {2{cba_rise[0]}} : cba_rise;
  logic [LANE_W-1:0] a_o [LANES];
  logic [LANE_W-1:0] b_o [LANES];
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      wire logic [CTL_W-1:0] c = (g == 0) ? ctl_lo_ff : ctl_up;
      xcvr_lane u_lane (
        .pclk(pclk),
        .presetn(presetn),
        .a_in(a_s2_ff[g*LANE_W +: LANE_W]),
        .b_in(b_s2_ff[g*LANE_W +: LANE_W]),
        .oe_n(c[CTL_OE_N]),
        .dir(c[CTL_DIR]),
        .a_to_b_source_select(c[CTL_A2B_SEL]),
        .b_to_a_source_select(c[CTL_B2A_SEL]),
        .a_to_b_capture_clock(cab_l[g]),
        .b_to_a_capture_clock(cba_l[g]),
        .a_out_ff(a_o[g]),
        .a_oe_ff(a_oe_l[g]),
        .b_out_ff(b_o[g]),
        .b_oe_ff(b_oe_l[g]),
        .ab_store_ff(ab_st[g]),
        .ba_store_ff(ba_st[g])
      );
      // lane outputs are flops inside the lane; these are wires only
      assign a_out[g*LANE_W +: LANE_W] = a_o[g];
      assign b_out[g*LANE_W +: LANE_W] = b_o[g];
      assign a_oe[g*LANE_W +: LANE_W] = {LANE_W{a_oe_l[g]}};
      assign b_oe[g*LANE_W +: LANE_W] = {LANE_W{b_oe_l[g]}};
    end
  endgenerate
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_no_clash: assert property (@(posedge pclk) disable iff (!presetn)
    (a_oe & b_oe) == 16'h0000) else $error("bus clash");
  a_wide_tie: assert property (@(posedge pclk) disable iff (!presetn)
    mode_wide_ff && $stable(mode_wide_ff) && $stable(ctl_lo_ff)
    |-> a_oe_l[0] == a_oe_l[1]) else $error("lanes differ");
endmodule

// file: design/xcvr_pkg.sv
// package: constants for the registered bus transceiver and its register map
// Functional notes
// - two 8-bit lanes or one 16-bit lane
// - capture clocks' rising edges store A and B
// - undriven bus storable into either or both registers
// - source select picks live or stored data
// - live/stored switch makes no glitch on bus
// - enable low: direction picks the driven bus
// - enable high: drive nothing, capture still works
// - capture keeps working while outputs are disabled
// - never drive both buses at once within one lane
// - dir low drives A from B live/stored
// - dir high drives B from A live/stored
package xcvr_pkg;
  // ----------------------------------------------------------------
  // datapath geometry
  // ----------------------------------------------------------------
  localparam int LANE_W = 8;
  localparam int LANES = 2;
  localparam int BUS_W = LANE_W * LANES;
  localparam int CTL_W = 5;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_CTL_LO = 12'h004;
  localparam logic [11:0] OFS_CTL_HI = 12'h008;
  localparam logic [11:0] OFS_STORE = 12'h00c;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  // ----------------------------------------------------------------
  // control field positions (per lane control word)
  // ----------------------------------------------------------------
  localparam int CTL_OE_N = 0;
  localparam int CTL_DIR = 1;
  localparam int CTL_A2B_SEL = 2;
  localparam int CTL_B2A_SEL = 3;
  localparam int CTL_KEEP = 4;
  localparam int MODE_WIDE = 0;
  // ----------------------------------------------------------------
  // reset values: outputs off, live data, split lanes
  // ----------------------------------------------------------------
  localparam logic [CTL_W-1:0] CTL_RST = 5'h01;
  localparam logic MODE_RST = 1'b0;
endpackage

// file: design/xcvr_lane.sv
// module: one 8-bit lane with two capture registers and output muxes
`timescale 1ns/10ps
module xcvr_lane
  import xcvr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [LANE_W-1:0] a_in,
  input wire logic [LANE_W-1:0] b_in,
  input wire logic oe_n,
  input wire logic dir,
  input wire logic a_to_b_source_select,
  input wire logic b_to_a_source_select,
  input wire logic a_to_b_capture_clock,
  input wire logic b_to_a_capture_clock,
  output logic [LANE_W-1:0] a_out_ff,
  output logic a_oe_ff,
  output logic [LANE_W-1:0] b_out_ff,
  output logic b_oe_ff,
  output logic [LANE_W-1:0] ab_store_ff,
  output logic [LANE_W-1:0] ba_store_ff
);
  // ----------------------------------------------------------------
  // capture registers
  // ----------------------------------------------------------------
  // capture ignores oe and dir so isolation still stores data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_store_ff <= 8'h00;
      ba_store_ff <= 8'h00;
    end else begin
      if (a_to_b_capture_clock) begin
        ab_store_ff <= a_in;
      end
      if (b_to_a_capture_clock) begin
        ba_store_ff <= b_in;
      end
    end
  end
  // ----------------------------------------------------------------
  // output selection
  // ----------------------------------------------------------------
  // registered mux: the bus only changes at a clock edge, no glitch
  wire logic [LANE_W-1:0] nxt_b_out =
    a_to_b_source_select ? ab_store_ff : a_in;
  wire logic [LANE_W-1:0] nxt_a_out =
    b_to_a_source_select ? ba_store_ff : b_in;
  // exclusive enables, at most one set, both clear while oe_n is high
  wire logic nxt_a_oe = !oe_n && !dir;
  wire logic nxt_b_oe = !oe_n && dir;
  // outputs update every edge from the decoded selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_out_ff <= 8'h00;
      b_out_ff <= 8'h00;
      a_oe_ff <= 1'b0;
      b_oe_ff <= 1'b0;
    end else begin
      a_out_ff <= nxt_a_out;
      b_out_ff <= nxt_b_out;
      a_oe_ff <= nxt_a_oe;
      b_oe_ff <= nxt_b_oe;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_one_driver: assert property (@(posedge pclk) disable iff (!presetn)
    !(a_oe_ff && b_oe_ff)) else $error("both buses driven");
  a_idle_off: assert property (@(posedge pclk) disable iff (!presetn)
    oe_n |=> !a_oe_ff && !b_oe_ff)
    else $error("bus driven while disabled");
  a_dir_pick: assert property (@(posedge pclk) disable iff (!presetn)
    !oe_n |=> (b_oe_ff == $past(dir)) && (a_oe_ff != $past(dir)))
    else $error("wrong bus driven");
  a_live_b2a: assert property (@(posedge pclk) disable iff (!presetn)
    !b_to_a_source_select |=> a_out_ff == $past(b_in))
    else $error("A live data wrong");
  a_live_a2b: assert property (@(posedge pclk) disable iff (!presetn)
    !a_to_b_source_select |=> b_out_ff == $past(a_in))
    else $error("B live data wrong");
  a_stored_b2a: assert property (@(posedge pclk) disable iff (!presetn)
    b_to_a_source_select |=> a_out_ff == $past(ba_store_ff))
    else $error("A stored data wrong");
  a_stored_a2b: assert property (@(posedge pclk) disable iff (!presetn)
    a_to_b_source_select |=> b_out_ff == $past(ab_store_ff))
    else $error("B stored data wrong");
  a_cap_b: assert property (@(posedge pclk) disable iff (!presetn)
    b_to_a_capture_clock |=> ba_store_ff == $past(b_in))
    else $error("B not captured");
  a_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    a_to_b_capture_clock |=> ab_store_ff == $past(a_in))
    else $error("A not captured");
  a_hold_b: assert property (@(posedge pclk) disable iff (!presetn)
    !b_to_a_capture_clock |=> $stable(ba_store_ff))
    else $error("B store changed");
endmodule

// file: verif/bus_partner.sv
// partner: other logic on the A and B buses, yielding to the transceiver
`timescale 1ns/10ps
module bus_partner
  import xcvr_pkg::*;
(
  input wire logic [BUS_W-1:0] a_out,
  input wire logic [BUS_W-1:0] a_oe,
  input wire logic [BUS_W-1:0] b_out,
  input wire logic [BUS_W-1:0] b_oe,
  input wire logic [BUS_W-1:0] a_val,
  input wire logic [BUS_W-1:0] b_val,
  output logic [BUS_W-1:0] a_in,
  output logic [BUS_W-1:0] b_in
);
  // ----------------------------------------------------------------
  // wire levels
  // ----------------------------------------------------------------
  // we let go bit by bit wherever the transceiver drives, so no wire
  // ever has two sources and the pins read back what was driven
  assign a_in = (a_oe & a_out) | (~a_oe & a_val);
  assign b_in = (b_oe & b_out) | (~b_oe & b_val);
endmodule

// file: verif/test_registered_bus_transceiver.sv
// testbench: apb-driven checks of the registered bus transceiver
`timescale 1ns/10ps
module test_registered_bus_transceiver
  import xcvr_pkg::*;
;
  // one row: lane control word and the masked drive values it gives
  typedef struct packed {
    logic [4:0] c;
    logic [15:0] ea;
    logic [15:0] eb;
  } row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [BUS_W-1:0] a_in, a_out, a_oe, b_in, b_out, b_oe, a_val, b_val;
  logic [LANES-1:0] ab_clk, ba_clk;
  logic er, da, db;
  int mismatches, checked;
  // stores hold 5a3c (a to b) and c3a5 (b to a); live a 1111, b 2222
  row_t rows[7] = '{'{5'h01, 16'h0, 16'h0}, '{5'h00, 16'h2222, 16'h0},
    '{5'h08, 16'hc3a5, 16'h0}, '{5'h04, 16'h2222, 16'h0},
    '{5'h02, 16'h0, 16'h1111}, '{5'h06, 16'h0, 16'h5a3c},
    '{5'h0f, 16'h0, 16'h0}};
  xcvr_top xcvr_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .a_in(a_in),
    .a_out(a_out), .a_oe(a_oe), .b_in(b_in), .b_out(b_out), .b_oe(b_oe),
    .a_to_b_capture_clock(ab_clk), .b_to_a_capture_clock(ba_clk));
  bus_partner bus_partner_i (.a_out(a_out), .a_oe(a_oe), .b_out(b_out),
    .b_oe(b_oe), .a_val(a_val), .b_val(b_val), .a_in(a_in), .b_in(b_in));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; entered just after a rising edge
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // an idle edge so the next call never reassigns psel in this step
    @(posedge pclk);
  endtask
  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // pins are synchronised inside, so the high phase lasts two cycles and the low phase six
  task cap(input logic [1:0] ab, input logic [1:0] ba);
    ab_clk <= ab;
    ba_clk <= ba;
    idle(2);
    ab_clk <= 2'b00;
    ba_clk <= 2'b00;
    idle(6);
  endtask
  task finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // the tests need well under a thousand cycles
  initial begin
    #(8 * 4000);
    mismatches++;
    finish_test();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    a_val = 16'h5a3c;
    b_val = 16'hc3a5;
    ab_clk = 2'b00;
    ba_clk = 2'b00;
    idle(2);
    presetn <= 1'b1;
    idle(1);
    apb(1'b0, OFS_CTL_HI, 32'h0);
    chk(rd, 32'h1);
    chk(a_oe | b_oe, 32'h0);
    // isolation: both buses stored in both lanes with outputs off
    cap(2'b11, 2'b11);
    apb(1'b0, OFS_STORE, 32'h0);
    chk(rd, 32'hc3a55a3c);
    $display("test reset and isolated capture done");
    a_val <= 16'h1111;
    b_val <= 16'h2222;
    foreach (rows[i]) begin
      apb(1'b1, OFS_CTL_LO, {27'h0, rows[i].c});
      apb(1'b1, OFS_CTL_HI, {27'h0, rows[i].c});
      idle(5);
      da = !rows[i].c[0] && !rows[i].c[1];
      db = !rows[i].c[0] && rows[i].c[1];
      chk(a_oe, {16'h0, {16{da}}});
      chk(b_oe, {16'h0, {16{db}}});
      chk(a_out & a_oe, rows[i].ea);
      chk(b_out & b_oe, rows[i].eb);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd, {28'h0, db, db, da, da});
      $display("test row %0d done", i);
    end
    // lanes split: lane 0 drives B, lane 1 drives A
    apb(1'b1, OFS_CTL_LO, 32'h2);
    apb(1'b1, OFS_CTL_HI, 32'h0);
    idle(5);
    chk(b_oe, 32'h00ff);
    chk(a_oe, 32'hff00);
    chk(b_out & b_oe, 32'h0011);
    // only lane 1 b to a capture rises; undriven B lane 1 is stored
    b_val <= 16'h9999;
    cap(2'b00, 2'b10);
    apb(1'b0, OFS_STORE, 32'h0);
    chk(rd, 32'h99a55a3c);
    // refused accesses: unmapped read, write to a read-only word
    apb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, OFS_STORE, 32'h0);
    chk({31'h0, er}, 32'h1);
    // wide mode: lane 1 follows lane 0 controls
    apb(1'b1, OFS_MODE, 32'h1);
    idle(5);
    chk(b_oe, 32'hffff);
    chk(a_oe, 32'h0);
    // wide capture: lane 0 capture clock loads both lanes from live A
    cap(2'b01, 2'b00);
    apb(1'b0, OFS_STORE, 32'h0);
    chk(rd, 32'h99a51111);
    $display("test split, partial capture and wide mode done");
    // reset in mid-run turns every driver off
    presetn <= 1'b0;
    idle(1);
    chk(a_oe | b_oe, 32'h0);
    presetn <= 1'b1;
    idle(1);
    // registers are back at their reset values: outputs off, split
    apb(1'b0, OFS_CTL_LO, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, OFS_MODE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_STORE, 32'h0);
    chk(rd, 32'h0);
    $display("test second reset done");
    finish_test();
  end
endmodule
